/* File: hw/codec_irq_defs.svh */
/*
 * Offsets, field positions and reset values of the codec interrupt logic.
 * Assumes an 8-bit register port with 8-bit offsets.
 */
// Overview of operation
// - status bit 1 records ADC overrange
// - status bit 0 records ADC underrange
// - enabled source sets status, drives pin
// - disabled source sets nothing, pin untouched
// - enable bit position matches status bit
// - trigger code high/low bits per source
// - codes: rise, fall, level, reserved
// - rising mode: assert on condition start
// - falling mode: assert on condition end
// - level mode: assert while condition persists
// - status sticky, cleared by reading it
// - disabled bits read zero, reset 00h
// - polarity bit: push-pull high or open-drain low
`ifndef CODEC_IRQ_DEFS_SVH
`define CODEC_IRQ_DEFS_SVH

`define SRC_NUM        4
`define OFS_POL_CTL    8'h0c
`define OFS_FLAGS      8'h0d
`define OFS_MASK       8'h0e
`define OFS_TRIG_HI    8'h0f
`define OFS_TRIG_LO    8'h10
`define OFS_FLAG_CLR   8'h11

`define BIT_UNDERRANGE 0
`define BIT_OVERRANGE  1
`define BIT_DAC_CLOCK  2
`define BIT_ADC_CLOCK  3
`define BIT_POLARITY   0

`define RST_FLAGS      4'h0
`define RST_MASK       4'h0
`define RST_TRIG       4'h0
`define RST_POLARITY   1'b0
`define RST_RDATA      8'h00

`endif

/* File: hw/codec_irq_pkg.sv */
/*
 * Types of the codec interrupt logic: trigger codes, register port and
 * interrupt pin bundles. Assumes the constants header for widths.
 */
package codec_irq_pkg;

	typedef enum logic [1:0] {
		TRIG_RISE  = 2'b00,
		TRIG_FALL  = 2'b01,
		TRIG_LEVEL = 2'b10,
		TRIG_RSVD  = 2'b11
	} trig_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic out;
		logic oe;
	} irq_pin_t;

endpackage

/* File: hw/codec_interrupt_logic.sv */
/*
 * Interrupt logic of a stereo codec: four fault sources with per-source
 * trigger mode and enable, sticky read-to-clear flags, one interrupt pin.
 * Assumes a register master on clk with single-cycle strobes; the fault
 * inputs come from other clock domains and are synchronised here.
 */
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "codec_irq_defs.svh"

module codec_interrupt_logic
(
	input  wire  logic                    clk,
	input  wire  logic                    sys_rst,
	input  wire  codec_irq_pkg::reg_req_t req,
	output logic [7:0]                    rdata,
	input  wire  logic [`SRC_NUM-1:0]     fault_cond,
	output logic                          irq,
	output codec_irq_pkg::irq_pin_t       irq_pin
);

	logic [`SRC_NUM-1:0] meta_reg;
	logic [`SRC_NUM-1:0] sync_reg;
	logic [`SRC_NUM-1:0] prev_reg;
	logic [`SRC_NUM-1:0] meta_next;
	logic [`SRC_NUM-1:0] sync_next;
	logic [`SRC_NUM-1:0] prev_next;

	logic [`SRC_NUM-1:0] flags_reg;
	logic [`SRC_NUM-1:0] flags_next;
	logic [`SRC_NUM-1:0] mask_reg;
	logic [`SRC_NUM-1:0] mask_next;
	logic [`SRC_NUM-1:0] trig_hi_reg;
	logic [`SRC_NUM-1:0] trig_hi_next;
	logic [`SRC_NUM-1:0] trig_lo_reg;
	logic [`SRC_NUM-1:0] trig_lo_next;
	logic                pol_reg;
	logic                pol_next;
	logic [7:0]          rdata_reg;
	logic [7:0]          rdata_next;
	logic                irq_reg;
	logic                irq_next;
	codec_irq_pkg::irq_pin_t pin_reg;
	codec_irq_pkg::irq_pin_t pin_next;

	logic [`SRC_NUM-1:0] hit;
	logic [`SRC_NUM-1:0] level_live;
	logic [`SRC_NUM-1:0] clr;

	assign rdata   = rdata_reg;
	assign irq     = irq_reg;
	assign irq_pin = pin_reg;

	// two stages before any logic; prev_reg keeps the last synced level
	always_comb
	begin
		meta_next = fault_cond;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end
		else
		begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	// per-source trigger decode
	genvar i;
	generate
		for (i = 0; i < `SRC_NUM; i++)
		begin : g_src
			codec_irq_pkg::trig_mode_t mode;

			assign mode = codec_irq_pkg::trig_mode_t'(
				{trig_hi_reg[i], trig_lo_reg[i]});

			always_comb
			begin
				hit[i]        = 1'b0;
				level_live[i] = 1'b0;
				case (mode)
					codec_irq_pkg::TRIG_RISE:
						hit[i] = sync_reg[i] & ~prev_reg[i];
					codec_irq_pkg::TRIG_FALL:
						hit[i] = ~sync_reg[i] & prev_reg[i];
					codec_irq_pkg::TRIG_LEVEL:
					begin
						hit[i]        = sync_reg[i];
						level_live[i] = sync_reg[i];
					end
					// reserved code raises nothing
					default:
						hit[i] = 1'b0;
				endcase
			end
		end
	endgenerate

	// register writes; upper four bits are dropped, upper seven for polarity
	always_comb
	begin
		mask_next    = mask_reg;
		trig_hi_next = trig_hi_reg;
		trig_lo_next = trig_lo_reg;
		pol_next     = pol_reg;
		if (req.wr)
		begin
			if (req.addr == `OFS_MASK)
				mask_next = req.wdata[`SRC_NUM-1:0];
			else if (req.addr == `OFS_TRIG_HI)
				trig_hi_next = req.wdata[`SRC_NUM-1:0];
			else if (req.addr == `OFS_TRIG_LO)
				trig_lo_next = req.wdata[`SRC_NUM-1:0];
			else if (req.addr == `OFS_POL_CTL)
				pol_next = req.wdata[`BIT_POLARITY];
		end
	end

	// flags: set beats clear; a disabled source never lands
	always_comb
	begin
		clr = '0;
		if (req.rd && req.addr == `OFS_FLAGS)
			clr = '1;
		else if (req.wr && req.addr == `OFS_FLAG_CLR)
			clr = req.wdata[`SRC_NUM-1:0];
		flags_next = ((flags_reg & ~clr) | (hit & mask_reg))
			& mask_next;
	end

	// read data valid in the cycle after the strobe only
	always_comb
	begin
		rdata_next = `RST_RDATA;
		if (req.rd)
		begin
			if (req.addr == `OFS_FLAGS)
				rdata_next = {4'h0, flags_reg & mask_reg};
			else if (req.addr == `OFS_MASK)
				rdata_next = {4'h0, mask_reg};
			else if (req.addr == `OFS_TRIG_HI)
				rdata_next = {4'h0, trig_hi_reg};
			else if (req.addr == `OFS_TRIG_LO)
				rdata_next = {4'h0, trig_lo_reg};
			else if (req.addr == `OFS_POL_CTL)
				rdata_next = {7'h00, pol_reg};
			else
				rdata_next = `RST_RDATA;
		end
	end

	// level sources keep irq and the pin asserted even right after a read
	always_comb
	begin
		irq_next = (|flags_next) | (|(level_live & mask_next));
		pin_next.out = pol_next & irq_next;
		pin_next.oe  = pol_next | irq_next;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flags_reg   <= `RST_FLAGS;
			mask_reg    <= `RST_MASK;
			trig_hi_reg <= `RST_TRIG;
			trig_lo_reg <= `RST_TRIG;
			pol_reg     <= `RST_POLARITY;
			rdata_reg   <= `RST_RDATA;
			irq_reg     <= 1'b0;
			pin_reg     <= '0;
		end
		else
		begin
			flags_reg   <= flags_next;
			mask_reg    <= mask_next;
			trig_hi_reg <= trig_hi_next;
			trig_lo_reg <= trig_lo_next;
			pol_reg     <= pol_next;
			rdata_reg   <= rdata_next;
			irq_reg     <= irq_next;
			pin_reg     <= pin_next;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	logic quiet_bus;
	assign quiet_bus = !req.wr && !req.rd;

	a_overrange_flag_set: assert property (
		(hit[`BIT_OVERRANGE] && mask_reg[`BIT_OVERRANGE] && !req.wr)
		|=> flags_reg[`BIT_OVERRANGE] && irq)
		else $error("overrange event did not set its flag");

	a_underrange_flag_set: assert property (
		(hit[`BIT_UNDERRANGE] && mask_reg[`BIT_UNDERRANGE] && !req.wr)
		|=> flags_reg[`BIT_UNDERRANGE] && irq)
		else $error("underrange event did not set its flag");

	a_flag_drives_irq: assert property (
		(|flags_reg) |-> irq)
		else $error("set flag without interrupt");

	a_masked_flag_zero: assert property (
		(flags_reg & ~mask_reg) == 4'h0)
		else $error("flag set for a disabled source");

	a_mask_write_lands: assert property (
		(req.wr && req.addr == `OFS_MASK)
		|=> mask_reg == $past(req.wdata[3:0]))
		else $error("mask write not stored in place");

	a_trig_write_lands: assert property (
		(req.wr && req.addr == `OFS_TRIG_HI)
		|=> trig_hi_reg == $past(req.wdata[3:0]))
		else $error("trigger high write not stored");

	a_rise_raises_irq: assert property (
		($rose(sync_reg[0]) && mask_reg[0] && !trig_hi_reg[0]
		&& !trig_lo_reg[0] && quiet_bus) |=> irq)
		else $error("rising condition missed");

	a_fall_raises_irq: assert property (
		($fell(sync_reg[1]) && mask_reg[1] && !trig_hi_reg[1]
		&& trig_lo_reg[1] && quiet_bus) |=> irq)
		else $error("falling condition missed");

	a_level_holds_irq: assert property (
		(sync_reg[2] && mask_reg[2] && trig_hi_reg[2] && !trig_lo_reg[2]
		&& !req.wr) |=> irq)
		else $error("level condition did not hold interrupt");

	a_read_clears_flags: assert property (
		(req.rd && req.addr == `OFS_FLAGS && (hit & mask_reg) == 4'h0)
		|=> flags_reg == 4'h0 && rdata == {4'h0, $past(flags_reg)})
		else $error("flag read did not return and clear");

	a_pin_polarity: assert property (
		pol_reg ? (irq_pin.oe && irq_pin.out == irq)
			: (!irq_pin.out && irq_pin.oe == irq))
		else $error("interrupt pin drive wrong for polarity");

	a_reserved_zero: assert property (
		req.rd |=> rdata[7:4] == 4'h0)
		else $error("reserved bits read nonzero");

	a_rdata_one_cycle: assert property (
		!req.rd |=> rdata == 8'h00)
		else $error("read data outside its cycle");

	a_dac_clock_flag_set: assert property (
		(hit[`BIT_DAC_CLOCK] && mask_reg[`BIT_DAC_CLOCK] && !req.wr)
		|=> flags_reg[`BIT_DAC_CLOCK] && irq)
		else $error("dac clock fault event did not set its flag");

	a_adc_clock_flag_set: assert property (
		(hit[`BIT_ADC_CLOCK] && mask_reg[`BIT_ADC_CLOCK] && !req.wr)
		|=> flags_reg[`BIT_ADC_CLOCK] && irq)
		else $error("adc clock fault event did not set its flag");

	a_masked_event_silent: assert property (
		(!mask_reg[0] && !req.wr) |=> !flags_reg[0])
		else $error("disabled source set its flag");

	a_masked_irq_quiet: assert property (
		(mask_reg == 4'h0 && !req.wr) |=> !irq)
		else $error("interrupt with every source disabled");

	a_reserved_code_silent: assert property (
		(trig_hi_reg[1] && trig_lo_reg[1]) |-> !hit[1])
		else $error("reserved trigger code raised an event");

	a_rise_not_on_fall: assert property (
		($fell(sync_reg[0]) && !trig_hi_reg[0] && !trig_lo_reg[0])
		|-> !hit[0])
		else $error("rising mode fired on a falling condition");

	a_fall_not_on_rise: assert property (
		($rose(sync_reg[1]) && !trig_hi_reg[1] && trig_lo_reg[1])
		|-> !hit[1])
		else $error("falling mode fired on a rising condition");

	a_trig_lo_write_lands: assert property (
		(req.wr && req.addr == `OFS_TRIG_LO)
		|=> trig_lo_reg == $past(req.wdata[3:0]))
		else $error("trigger low write not stored");

	a_pol_write_lands: assert property (
		(req.wr && req.addr == `OFS_POL_CTL)
		|=> pol_reg == $past(req.wdata[0]))
		else $error("polarity write not stored");

	// without a strobe nothing may drop a flag
	a_flag_sticky: assert property (
		(flags_reg[0] && !req.rd && !req.wr) |=> flags_reg[0])
		else $error("flag dropped without a clear");

	a_write_clear: assert property (
		(req.wr && req.addr == `OFS_FLAG_CLR && (hit & mask_reg) == 4'h0)
		|=> (flags_reg & $past(req.wdata[3:0])) == 4'h0)
		else $error("write clear left a flag set");

	a_set_beats_read: assert property (
		(req.rd && req.addr == `OFS_FLAGS && hit[1] && mask_reg[1])
		|=> flags_reg[1])
		else $error("event lost under a flag read");

	a_open_drain_low: assert property (
		!pol_reg |-> !irq_pin.out)
		else $error("open drain pin driven high");

	a_sync_two_stage: assert property (
		sync_reg == $past(fault_cond, 2))
		else $error("fault input not two stages deep");

	a_unmapped_read_zero: assert property (
		(req.rd && (req.addr < `OFS_POL_CTL || req.addr > `OFS_FLAG_CLR))
		|=> rdata == 8'h00)
		else $error("unmapped read returned data");

	c_write_clear: cover property (
		req.wr && req.addr == `OFS_FLAG_CLR ##1 !irq);
	c_rise_irq: cover property (
		$rose(sync_reg[0]) && mask_reg[0] ##1 $rose(irq));
	c_level_after_read: cover property (
		level_live[2] && mask_reg[2] && req.rd ##1 irq);
	c_set_and_clear: cover property (
		(hit & mask_reg) != 4'h0 && req.rd && req.addr == `OFS_FLAGS);
	c_open_drain_low: cover property (!pol_reg && irq_pin.oe);

endmodule // codec_interrupt_logic

/* File: tb/codec_host_model.sv */
/*
 * Host side of the interrupt pin: resolves the wire level.
 * Assumes an external pull-up on the pin, as open-drain mode needs.
 */
`timescale 1ns/1ps

module codec_host_model
(
	input  wire codec_irq_pkg::irq_pin_t irq_pin,
	output logic                         pin_level
);
	// released pin floats up to the pull-up level
	assign pin_level = irq_pin.oe ? irq_pin.out : 1'b1;
endmodule // codec_host_model

/* File: tb/codec_interrupt_logic_tb.sv */
/*
 * Bench for the codec interrupt logic: stimulus, model and checks.
 * Assumes the design under hw/ and the host pin model.
 */
`timescale 1ns/1ps
`include "codec_irq_defs.svh"

module codec_interrupt_logic_tb;
	logic                    clk = 1'b0;
	logic                    sys_rst = 1'b1;
	codec_irq_pkg::reg_req_t req = '0;
	logic [3:0]              cond = 4'h0;
	logic [7:0]              rdata;
	logic                    irq;
	codec_irq_pkg::irq_pin_t irq_pin;
	logic                    pin_level;
	logic                    pol = 1'b0;
	int                      err_count = 0;
	int                      cmp_count = 0;
	int                      s;
	int                      e_r;
	int                      e_f;

	always #2 clk = ~clk;

	codec_interrupt_logic DUT (.clk(clk), .sys_rst(sys_rst), .req(req),
		.rdata(rdata), .fault_cond(cond), .irq(irq), .irq_pin(irq_pin));
	codec_host_model host (.irq_pin(irq_pin), .pin_level(pin_level));

	task wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask

	task chk_irq(input logic e);
		chk("irq", {7'h0, e}, {7'h0, irq});
		chk("pin", {7'h0, pol ? e : ~e}, {7'h0, pin_level});
	endtask

	// three edges through sync and flag register, one spare
	task settle;
		repeat (4) @(posedge clk);
		#1;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		wrap_up;
	end

	initial
	begin
		void'($urandom(74287));
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`OFS_FLAGS, 8'h00);
		rd(`OFS_TRIG_HI, 8'h00);
		rd(`OFS_TRIG_LO, 8'h00);
		wr(`OFS_MASK, 8'hff);
		rd(`OFS_MASK, 8'h0f);
		wr(`OFS_FLAGS, 8'hff);
		rd(8'h20, 8'h00);
		wr(`OFS_MASK, 8'h00);
		@(posedge clk) cond <= 4'hf;
		settle;
		chk_irq(1'b0);
		rd(`OFS_FLAGS, 8'h00);
		@(posedge clk) cond <= 4'h0;
		settle;
		for (int m = 0; m < 4; m++)
		begin
			s = $urandom_range(3);
			pol = m[0];
			wr(`OFS_POL_CTL, {7'h0, pol});
			wr(`OFS_MASK, 8'h01 << s);
			wr(`OFS_TRIG_HI, 8'(m[1]) << s);
			wr(`OFS_TRIG_LO, 8'(m[0]) << s);
			rd(`OFS_FLAGS, 8'h00);
			e_r = (m == 0 || m == 2);
			e_f = (m == 1 || m == 2);
			@(posedge clk) cond <= 4'h1 << s;
			settle;
			chk_irq(e_r[0]);
			rd(`OFS_FLAGS, 8'(e_r) << s);
			settle;
			chk_irq(m == 2);
			@(posedge clk) cond <= 4'h0;
			settle;
			chk_irq(e_f[0]);
			rd(`OFS_FLAGS, 8'(e_f) << s);
			settle;
			chk_irq(1'b0);
			$display("mode %0d source %0d done", m, s);
		end
		pol = 1'b0;
		wr(`OFS_POL_CTL, 8'hff);
		rd(`OFS_POL_CTL, 8'h01);
		wr(`OFS_POL_CTL, 8'h00);
		wr(`OFS_TRIG_HI, 8'h00);
		wr(`OFS_TRIG_LO, 8'h00);
		wr(`OFS_MASK, 8'h01);
		@(posedge clk) cond <= 4'h1;
		settle;
		chk_irq(1'b1);
		wr(`OFS_FLAG_CLR, 8'h01);
		settle;
		chk_irq(1'b0);
		rd(`OFS_FLAGS, 8'h00);
		@(posedge clk) cond <= 4'h0;
		settle;
		$display("write clear done");
		wrap_up;
	end
endmodule // codec_interrupt_logic_tb
